// *** rtl/srm_monitor.sv ***
// Second-system range and rotation monitor, top level
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Notes on behaviour
// - Upper voltage bound 100-150 %, default 110
// - Lower voltage bound 50-100 %, default 90
// - Voltage in-window flag as limit switch
// - Upper frequency bound 100-150 %, default 105
// - Lower frequency bound 50-100 %, default 95
// - Frequency in-window flag as limit switch
// - Both windows gate dead-bus closure and synchronising
// - Forward is 1-2-3, reverse is 1-3-2
// - Alarm when measured sequence differs from expected
// - Alarm drives its own command flag
// - Three-phase check only above half rated voltage
// - Single-phase mode uses configured sequence setting
// - Sequence monitoring enable, off after reset
// - Expected sequence setting, forward after reset
// - Alarm class A-F or control, default F
// - Self-acknowledge clears alarm when fault gone
// - Otherwise alarm latched until acknowledged
// - Lockable check pauses while monitoring lock set
// - Breaker block only for classes C, D
// - Expected direction shown on an output
// - Voltage basis phase-phase or phase-neutral
// ************************************************************
module srm_monitor (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        meas_valid,
    input  wire logic [15:0] meas_volt_pp,
    input  wire logic [15:0] meas_volt_pn,
    input  wire logic [15:0] meas_freq,
    input  wire logic        meas_seq_reverse,
    input  wire logic        lock_status,
    input  wire logic        ext_ack,
    output logic             volt_ok,
    output logic             freq_ok,
    output logic             close_permit,
    output logic             seq_alarm,
    output logic             breaker_block,
    output logic      [2:0]  alarm_class,
    output logic             expected_reverse
);

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] vhi_reg, vhi_next;
    logic [15:0] vlo_reg, vlo_next;
    logic [15:0] fhi_reg, fhi_next;
    logic [15:0] flo_reg, flo_next;
    logic [15:0] rvpp_reg, rvpp_next;
    logic [15:0] rvpn_reg, rvpn_next;
    logic [15:0] rf_reg, rf_next;
    logic        ack_reg, ack_next;

    // Out-of-range writes saturate so the window can never be inverted
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp

    always_comb begin
        ctrl_next = ctrl_reg;
        vhi_next  = vhi_reg;
        vlo_next  = vlo_reg;
        fhi_next  = fhi_reg;
        flo_next  = flo_reg;
        rvpp_next = rvpp_reg;
        rvpn_next = rvpn_reg;
        rf_next   = rf_reg;
        ack_next  = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                srm_pkg::ADDR_CTRL: begin
                    ctrl_next = reg_wdata;
                end
                srm_pkg::ADDR_VHI: begin
                    vhi_next = clamp(reg_wdata, srm_pkg::VHI_MIN,
                                     srm_pkg::VHI_MAX);
                end
                srm_pkg::ADDR_VLO: begin
                    vlo_next = clamp(reg_wdata, srm_pkg::VLO_MIN,
                                     srm_pkg::VLO_MAX);
                end
                srm_pkg::ADDR_FHI: begin
                    fhi_next = clamp(reg_wdata, srm_pkg::FHI_MIN,
                                     srm_pkg::FHI_MAX);
                end
                srm_pkg::ADDR_FLO: begin
                    flo_next = clamp(reg_wdata, srm_pkg::FLO_MIN,
                                     srm_pkg::FLO_MAX);
                end
                srm_pkg::ADDR_RATED_VPP: begin
                    rvpp_next = reg_wdata;
                end
                srm_pkg::ADDR_RATED_VPN: begin
                    rvpn_next = reg_wdata;
                end
                srm_pkg::ADDR_RATED_F: begin
                    rf_next = reg_wdata;
                end
                srm_pkg::ADDR_ACK: begin
                    ack_next = reg_wdata[0];
                end
                default: begin
                    ack_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= srm_pkg::CTRL_RST;
            vhi_reg  <= srm_pkg::VHI_RST;
            vlo_reg  <= srm_pkg::VLO_RST;
            fhi_reg  <= srm_pkg::FHI_RST;
            flo_reg  <= srm_pkg::FLO_RST;
            rvpp_reg <= srm_pkg::RATED_VPP_RST;
            rvpn_reg <= srm_pkg::RATED_VPN_RST;
            rf_reg   <= srm_pkg::RATED_F_RST;
            ack_reg  <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            vhi_reg  <= vhi_next;
            vlo_reg  <= vlo_next;
            fhi_reg  <= fhi_next;
            flo_reg  <= flo_next;
            rvpp_reg <= rvpp_next;
            rvpn_reg <= rvpn_next;
            rf_reg   <= rf_next;
            ack_reg  <= ack_next;
        end
    end

    // ************************************************************
    // Decoded settings
    // ************************************************************
    logic        mon_en;
    logic        exp_rev;
    logic        self_ack;
    logic        lockable;
    logic        pn_basis;
    logic [2:0]  class_code;
    logic [1:0]  mode_code;

    assign mon_en     = ctrl_reg[srm_pkg::CTRL_MON_EN];
    assign exp_rev    = ctrl_reg[srm_pkg::CTRL_EXP_REV];
    assign self_ack   = ctrl_reg[srm_pkg::CTRL_SELF_ACK];
    assign lockable   = ctrl_reg[srm_pkg::CTRL_LOCKABLE];
    assign pn_basis   = ctrl_reg[srm_pkg::CTRL_PN_BASIS];
    assign class_code = ctrl_reg[srm_pkg::CTRL_CLASS_LO +: 3];
    assign mode_code  = ctrl_reg[srm_pkg::CTRL_MODE_LO +: 2];

    // ************************************************************
    // Precomputed thresholds
    // ************************************************************
    // Products are registered so the per-sample path holds one multiply
    logic [31:0] thr_vhi_reg, thr_vhi_next;
    logic [31:0] thr_vlo_reg, thr_vlo_next;
    logic [31:0] thr_fhi_reg, thr_fhi_next;
    logic [31:0] thr_flo_reg, thr_flo_next;
    logic [31:0] thr_eval_reg, thr_eval_next;
    logic [15:0] rated_v;

    assign rated_v = pn_basis ? rvpn_reg : rvpp_reg;

    always_comb begin
        thr_vhi_next  = 32'(rated_v) * 32'(vhi_reg);
        thr_vlo_next  = 32'(rated_v) * 32'(vlo_reg);
        thr_fhi_next  = 32'(rf_reg) * 32'(fhi_reg);
        thr_flo_next  = 32'(rf_reg) * 32'(flo_reg);
        thr_eval_next = 32'(rated_v) * srm_pkg::EVAL_PCT;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            thr_vhi_reg  <= 32'h0000_0000;
            thr_vlo_reg  <= 32'h0000_0000;
            thr_fhi_reg  <= 32'h0000_0000;
            thr_flo_reg  <= 32'h0000_0000;
            thr_eval_reg <= 32'h0000_0000;
        end else begin
            thr_vhi_reg  <= thr_vhi_next;
            thr_vlo_reg  <= thr_vlo_next;
            thr_fhi_reg  <= thr_fhi_next;
            thr_flo_reg  <= thr_flo_next;
            thr_eval_reg <= thr_eval_next;
        end
    end

    // ************************************************************
    // Window comparisons
    // ************************************************************
    logic [31:0] v_scaled;
    logic [31:0] f_scaled;
    logic        v_win;
    logic        f_win;

    assign v_scaled = 32'(pn_basis ? meas_volt_pn : meas_volt_pp)
                      * srm_pkg::PCT_SCALE;
    assign f_scaled = 32'(meas_freq) * srm_pkg::PMIL_SCALE;

    srm_window_cmp u_volt_cmp (
        .meas_scaled (v_scaled),
        .thr_hi      (thr_vhi_reg),
        .thr_lo      (thr_vlo_reg),
        .in_window   (v_win)
    );

    srm_window_cmp u_freq_cmp (
        .meas_scaled (f_scaled),
        .thr_hi      (thr_fhi_reg),
        .thr_lo      (thr_flo_reg),
        .in_window   (f_win)
    );

    // ************************************************************
    // Phase sequence decision
    // ************************************************************
    logic single_phase;
    logic seq_rev;
    logic eval_ok;
    logic check_en;
    logic seq_fault;
    logic ack_any;
    logic alarm_w;

    assign single_phase = mode_code ==
        2'(srm_pkg::SRM_SINGLE_PHASE_TWO_WIRE);
    assign seq_rev   = single_phase ? ctrl_reg[srm_pkg::CTRL_SP_REV]
                                    : meas_seq_reverse;
    assign eval_ok   = single_phase || (v_scaled > thr_eval_reg);
    assign check_en  = mon_en && !(lockable && lock_status);
    assign seq_fault = check_en && eval_ok && (seq_rev != exp_rev);
    assign ack_any   = ack_reg || ext_ack;

    srm_seq_alarm u_alarm (
        .clk      (clk),
        .rst_b    (rst_b),
        .strobe   (meas_valid),
        .fault    (seq_fault),
        .self_ack (self_ack),
        .ack      (ack_any),
        .alarm    (alarm_w)
    );

    // ************************************************************
    // Output flags
    // ************************************************************
    logic volt_ok_reg, volt_ok_next;
    logic freq_ok_reg, freq_ok_next;
    logic permit_reg, permit_next;
    logic block_reg, block_next;
    logic seq_rev_reg, seq_rev_next;

    always_comb begin
        volt_ok_next = volt_ok_reg;
        freq_ok_next = freq_ok_reg;
        seq_rev_next = seq_rev_reg;
        if (meas_valid) begin
            volt_ok_next = v_win;
            freq_ok_next = f_win;
            seq_rev_next = seq_rev;
        end
        permit_next = volt_ok_next && freq_ok_next;
        // Only breaker-relevant classes may stop a closure
        block_next = alarm_w &&
            (class_code == 3'(srm_pkg::SRM_CLASS_C) ||
             class_code == 3'(srm_pkg::SRM_CLASS_D));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            volt_ok_reg <= 1'b0;
            freq_ok_reg <= 1'b0;
            permit_reg  <= 1'b0;
            block_reg   <= 1'b0;
            seq_rev_reg <= 1'b0;
        end else begin
            volt_ok_reg <= volt_ok_next;
            freq_ok_reg <= freq_ok_next;
            permit_reg  <= permit_next;
            block_reg   <= block_next;
            seq_rev_reg <= seq_rev_next;
        end
    end

    assign volt_ok          = volt_ok_reg;
    assign freq_ok          = freq_ok_reg;
    assign close_permit     = permit_reg;
    assign breaker_block    = block_reg;
    assign seq_alarm        = alarm_w;
    assign alarm_class      = ctrl_reg[srm_pkg::CTRL_CLASS_LO +: 3];
    assign expected_reverse = exp_rev;

    // ************************************************************
    // Read path
    // ************************************************************
    logic [15:0] rdata_reg, rdata_next;

    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                srm_pkg::ADDR_CTRL:      rdata_next = ctrl_reg;
                srm_pkg::ADDR_VHI:       rdata_next = vhi_reg;
                srm_pkg::ADDR_VLO:       rdata_next = vlo_reg;
                srm_pkg::ADDR_FHI:       rdata_next = fhi_reg;
                srm_pkg::ADDR_FLO:       rdata_next = flo_reg;
                srm_pkg::ADDR_RATED_VPP: rdata_next = rvpp_reg;
                srm_pkg::ADDR_RATED_VPN: rdata_next = rvpn_reg;
                srm_pkg::ADDR_RATED_F:   rdata_next = rf_reg;
                srm_pkg::ADDR_STATUS: begin
                    rdata_next = {10'h000, seq_rev_reg, permit_reg,
                                  block_reg, alarm_w, freq_ok_reg,
                                  volt_ok_reg};
                end
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_volt_over_high: assert property (
        meas_valid && v_scaled > thr_vhi_reg |=> !volt_ok)
        else $error("voltage above upper bound reported in window");
    a_volt_under_low: assert property (
        meas_valid && v_scaled < thr_vlo_reg |=> !volt_ok)
        else $error("voltage below lower bound reported in window");
    a_freq_over_high: assert property (
        meas_valid && f_scaled > thr_fhi_reg |=> !freq_ok)
        else $error("frequency above upper bound reported in window");
    a_freq_window_in: assert property (
        meas_valid && f_scaled >= thr_flo_reg && f_scaled <= thr_fhi_reg
        |=> freq_ok)
        else $error("frequency in window reported out of window");
    a_flag_hold: assert property (
        !meas_valid |=> $stable(volt_ok) && $stable(freq_ok))
        else $error("limit flags changed without a measurement");
    a_permit_both: assert property (
        close_permit == (volt_ok && freq_ok))
        else $error("close permit disagrees with window flags");
    a_seq_mismatch: assert property (
        meas_valid && mon_en && !lockable && single_phase &&
        ctrl_reg[srm_pkg::CTRL_SP_REV] != exp_rev |=> seq_alarm)
        else $error("sequence mismatch did not raise alarm");
    a_seq_disabled: assert property (
        !seq_alarm && !mon_en |=> !seq_alarm)
        else $error("alarm raised while monitoring off");
    a_lock_pause: assert property (
        !seq_alarm && lockable && lock_status |=> !seq_alarm)
        else $error("alarm raised while monitoring locked");
    a_alarm_latched: assert property (
        seq_alarm && !self_ack && !ack_any |=> seq_alarm)
        else $error("latched alarm cleared without acknowledge");
    a_block_class: assert property (
        breaker_block |-> $past(seq_alarm &&
        (alarm_class == 3'h2 || alarm_class == 3'h3)))
        else $error("breaker block without class C or D alarm");
    a_vhi_range: assert property (
        vhi_reg >= srm_pkg::VHI_MIN && vhi_reg <= srm_pkg::VHI_MAX)
        else $error("upper voltage bound outside its range");

    c_alarm_set:   cover property (!seq_alarm ##1 seq_alarm);
    c_self_clear:  cover property (seq_alarm && self_ack ##1 !seq_alarm);
    c_block:       cover property (breaker_block);
    c_permit_rise: cover property (!close_permit ##1 close_permit);

endmodule : srm_monitor
`default_nettype wire

// *** rtl/srm_pkg.sv ***
// Shared constants and types of the second-system range and rotation monitor
package srm_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_VHI     = 4'h1;
    localparam logic [3:0] ADDR_VLO     = 4'h2;
    localparam logic [3:0] ADDR_FHI     = 4'h3;
    localparam logic [3:0] ADDR_FLO     = 4'h4;
    localparam logic [3:0] ADDR_RATED_VPP = 4'h5;
    localparam logic [3:0] ADDR_RATED_VPN = 4'h6;
    localparam logic [3:0] ADDR_RATED_F = 4'h7;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;
    localparam logic [3:0] ADDR_ACK     = 4'h9;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int CTRL_MON_EN   = 0;
    localparam int CTRL_EXP_REV  = 1;
    localparam int CTRL_SELF_ACK = 2;
    localparam int CTRL_LOCKABLE = 3;
    localparam int CTRL_CLASS_LO = 4;
    localparam int CTRL_MODE_LO  = 7;
    localparam int CTRL_SP_REV   = 9;
    localparam int CTRL_PN_BASIS = 10;

    // ************************************************************
    // Reset values and setting ranges (voltage in %, frequency in 0.1 %)
    // ************************************************************
    localparam logic [15:0] CTRL_RST  = 16'h0050;
    localparam logic [15:0] VHI_RST   = 16'h006E;
    localparam logic [15:0] VHI_MIN   = 16'h0064;
    localparam logic [15:0] VHI_MAX   = 16'h0096;
    localparam logic [15:0] VLO_RST   = 16'h005A;
    localparam logic [15:0] VLO_MIN   = 16'h0032;
    localparam logic [15:0] VLO_MAX   = 16'h0064;
    localparam logic [15:0] FHI_RST   = 16'h041A;
    localparam logic [15:0] FHI_MIN   = 16'h03E8;
    localparam logic [15:0] FHI_MAX   = 16'h05DC;
    localparam logic [15:0] FLO_RST   = 16'h03B6;
    localparam logic [15:0] FLO_MIN   = 16'h01F4;
    localparam logic [15:0] FLO_MAX   = 16'h03E8;
    localparam logic [15:0] RATED_VPP_RST = 16'h0190;
    localparam logic [15:0] RATED_VPN_RST = 16'h00E7;
    localparam logic [15:0] RATED_F_RST   = 16'h01F4;
    localparam logic [31:0] PCT_SCALE  = 32'h0000_0064;
    localparam logic [31:0] PMIL_SCALE = 32'h0000_03E8;
    localparam logic [31:0] EVAL_PCT   = 32'h0000_0032;

    typedef enum logic [2:0] {
        SRM_CLASS_A, SRM_CLASS_B, SRM_CLASS_C, SRM_CLASS_D,
        SRM_CLASS_E, SRM_CLASS_F, SRM_CLASS_CTRL
    } srm_class_t;

    typedef enum logic [1:0] {
        SRM_THREE_PHASE_FOUR_WIRE, SRM_THREE_PHASE_THREE_WIRE,
        SRM_SINGLE_PHASE_TWO_WIRE
    } srm_wiring_t;

endpackage : srm_pkg

// *** rtl/srm_seq_alarm.sv ***
// Latching phase-sequence alarm with self-acknowledge
`timescale 1ns/1ps
`default_nettype none
module srm_seq_alarm (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic strobe,
    input  wire logic fault,
    input  wire logic self_ack,
    input  wire logic ack,
    output logic      alarm
);
    logic alarm_reg;
    logic alarm_next;

    always_comb begin
        alarm_next = alarm_reg;
        if (ack || (self_ack && strobe && !fault)) begin
            alarm_next = 1'b0;
        end
        // A fault in the clearing cycle must not be lost
        if (strobe && fault) begin
            alarm_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    assign alarm = alarm_reg;
endmodule : srm_seq_alarm
`default_nettype wire

// *** rtl/srm_window_cmp.sv ***
// Inclusive window comparator on scaled values
`timescale 1ns/1ps
`default_nettype none
module srm_window_cmp (
    input  wire logic [31:0] meas_scaled,
    input  wire logic [31:0] thr_hi,
    input  wire logic [31:0] thr_lo,
    output logic             in_window
);
    // A value sitting exactly on a bound is still permissible
    assign in_window = (meas_scaled <= thr_hi) && (meas_scaled >= thr_lo);
endmodule : srm_window_cmp
`default_nettype wire

// *** verification/srm_meas_model.sv ***
// Measurement front-end model for the monitor
`timescale 1ns/1ps
`default_nettype none
module srm_meas_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        fire,
    input  wire logic [15:0] v_pp,
    input  wire logic [15:0] v_pn,
    input  wire logic [15:0] f,
    input  wire logic        rev,
    output logic             meas_valid,
    output logic      [15:0] meas_volt_pp,
    output logic      [15:0] meas_volt_pn,
    output logic      [15:0] meas_freq,
    output logic             meas_seq_reverse
);
    // Results hold as levels until the next one, as a real front end does
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_valid       <= 1'b0;
            meas_volt_pp     <= 16'h0000;
            meas_volt_pn     <= 16'h0000;
            meas_freq        <= 16'h0000;
            meas_seq_reverse <= 1'b0;
        end else begin
            meas_valid <= fire;
            if (fire) begin
                meas_volt_pp     <= v_pp;
                meas_volt_pn     <= v_pn;
                meas_freq        <= f;
                meas_seq_reverse <= rev;
            end
        end
    end
endmodule : srm_meas_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench of the second-system monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        fire = 1'b0;
    logic [15:0] vpp = 16'h0000;
    logic [15:0] vpn = 16'h0000;
    logic [15:0] fq = 16'h0000;
    logic        rev = 1'b0;
    logic        mv, mr, lock_status = 1'b0, ext_ack = 1'b0;
    logic [15:0] mpp, mpn, mf;
    logic        volt_ok, freq_ok, permit, alarm, block, exp_rev;
    logic [2:0]  alarm_class;
    logic        rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          check_count = 0;
    logic [15:0] vt[8] = '{16'h0168, 16'h01B8, 16'h0167, 16'h01B9,
                           16'h0190, 16'h0190, 16'h0190, 16'h0190};
    logic [15:0] ft[8] = '{16'h01F4, 16'h01F4, 16'h01F4, 16'h01F4,
                           16'h01DB, 16'h020D, 16'h01DA, 16'h020E};
    always #2.5 clk = ~clk;
    srm_meas_model fe_u (.clk(clk), .rst_b(rst_b), .fire(fire), .v_pp(vpp),
        .v_pn(vpn), .f(fq), .rev(rev), .meas_valid(mv), .meas_volt_pp(mpp),
        .meas_volt_pn(mpn), .meas_freq(mf), .meas_seq_reverse(mr));
    srm_monitor dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas_valid(mv), .meas_volt_pp(mpp),
        .meas_volt_pn(mpn), .meas_freq(mf), .meas_seq_reverse(mr),
        .lock_status(lock_status), .ext_ack(ext_ack), .volt_ok(volt_ok),
        .freq_ok(freq_ok), .close_permit(permit), .seq_alarm(alarm),
        .breaker_block(block), .alarm_class(alarm_class),
        .expected_reverse(exp_rev));
    task automatic check(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    // Status bits 4..0: permit, block, alarm, freq ok, volt ok
    task automatic stat(input logic [15:0] v, f, input logic al, bk);
        logic vk;
        logic fk;
        vk = 32'(v) * srm_pkg::PCT_SCALE >= srm_pkg::RATED_VPP_RST
             * srm_pkg::VLO_RST && 32'(v) * srm_pkg::PCT_SCALE
             <= srm_pkg::RATED_VPP_RST * srm_pkg::VHI_RST;
        fk = 32'(f) * srm_pkg::PMIL_SCALE >= srm_pkg::RATED_F_RST
             * srm_pkg::FLO_RST && 32'(f) * srm_pkg::PMIL_SCALE
             <= srm_pkg::RATED_F_RST * srm_pkg::FHI_RST;
        rd(srm_pkg::ADDR_STATUS, {11'h0, vk & fk, bk, al, fk, vk}, 16'h001F);
        check("flags", {12'h0, permit, block, freq_ok, volt_ok},
              {12'h0, vk & fk, bk, fk, vk});
    endtask : stat
    task automatic meas(input logic [15:0] v, pn, f, input logic r);
        @(posedge clk);
        fire <= 1'b1;
        vpp  <= v;
        vpn  <= pn;
        fq   <= f;
        rev  <= r;
        @(posedge clk);
        fire <= 1'b0;
        // Capture edge, then the breaker flag's extra cycle, then one spare cycle
        repeat (3) @(posedge clk);
    endtask : meas
    always @(posedge clk) rd_pend <= reg_rd;
    always @(negedge clk) begin
        logic [31:0] e;
        if (rd_pend) begin
            e = exp_q.pop_front();
            check("reg_rdata", reg_rdata & e[31:16], e[15:0]);
        end
    end
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        logic [15:0] rv;
        void'($urandom(32'h56dc));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rd(srm_pkg::ADDR_CTRL, srm_pkg::CTRL_RST, 16'hFFFF);
        rd(srm_pkg::ADDR_VHI, srm_pkg::VHI_RST, 16'hFFFF);
        rd(srm_pkg::ADDR_VLO, srm_pkg::VLO_RST, 16'hFFFF);
        rd(srm_pkg::ADDR_FHI, srm_pkg::FHI_RST, 16'hFFFF);
        rd(srm_pkg::ADDR_FLO, srm_pkg::FLO_RST, 16'hFFFF);
        check("alarm_class", {13'h0, alarm_class}, 16'h0005);
        wr(srm_pkg::ADDR_VHI, 16'h00C8);
        rd(srm_pkg::ADDR_VHI, srm_pkg::VHI_MAX, 16'hFFFF);
        wr(srm_pkg::ADDR_VLO, 16'h0000);
        rd(srm_pkg::ADDR_VLO, srm_pkg::VLO_MIN, 16'hFFFF);
        wr(srm_pkg::ADDR_FHI, 16'hFFFF);
        rd(srm_pkg::ADDR_FHI, srm_pkg::FHI_MAX, 16'hFFFF);
        wr(srm_pkg::ADDR_FLO, 16'h0000);
        rd(srm_pkg::ADDR_FLO, srm_pkg::FLO_MIN, 16'hFFFF);
        wr(4'hB, 16'h1234);
        rd(4'hB, 16'h0000, 16'hFFFF);
        wr(srm_pkg::ADDR_VHI, srm_pkg::VHI_RST);
        wr(srm_pkg::ADDR_VLO, srm_pkg::VLO_RST);
        wr(srm_pkg::ADDR_FHI, srm_pkg::FHI_RST);
        wr(srm_pkg::ADDR_FLO, srm_pkg::FLO_RST);
        for (int i = 0; i < 24; i++) begin
            rv = (i < 8) ? vt[i] : 16'($urandom_range(999));
            meas(rv, 16'h0000, (i < 8) ? ft[i] : 16'($urandom_range(999)), 0);
            stat(rv, fq, 1'b0, 1'b0);
        end
        wr(srm_pkg::ADDR_CTRL, 16'h0450);
        meas(16'h0000, 16'h00D0, 16'h01F4, 1'b0);
        rd(srm_pkg::ADDR_STATUS, 16'h0013, 16'h001F);
        wr(srm_pkg::ADDR_CTRL, srm_pkg::CTRL_RST);
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b1);
        stat(16'h0190, 16'h01F4, 1'b0, 1'b0);
        wr(srm_pkg::ADDR_CTRL, 16'h0051);
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b1);
        check("seq_alarm", {15'h0, alarm}, 16'h0001);
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b0);
        stat(16'h0190, 16'h01F4, 1'b1, 1'b0);
        @(posedge clk);
        ext_ack <= 1'b1;
        @(posedge clk);
        ext_ack <= 1'b0;
        stat(16'h0190, 16'h01F4, 1'b0, 1'b0);
        meas(16'h00C8, 16'h0000, 16'h01F4, 1'b1);
        stat(16'h00C8, 16'h01F4, 1'b0, 1'b0);
        meas(16'h00C9, 16'h0000, 16'h01F4, 1'b1);
        check("seq_alarm", {15'h0, alarm}, 16'h0001);
        wr(srm_pkg::ADDR_ACK, 16'h0001);
        stat(16'h00C9, 16'h01F4, 1'b0, 1'b0);
        wr(srm_pkg::ADDR_CTRL, 16'h0059);
        lock_status <= 1'b1;
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b1);
        stat(16'h0190, 16'h01F4, 1'b0, 1'b0);
        wr(srm_pkg::ADDR_CTRL, 16'h0055);
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b1);
        stat(16'h0190, 16'h01F4, 1'b1, 1'b0);
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b0);
        stat(16'h0190, 16'h01F4, 1'b0, 1'b0);
        wr(srm_pkg::ADDR_CTRL, 16'h0023);
        @(negedge clk);
        check("expected_reverse", {15'h0, exp_rev}, 16'h0001);
        check("alarm_class", {13'h0, alarm_class}, 16'h0002);
        meas(16'h0190, 16'h0000, 16'h01F4, 1'b0);
        stat(16'h0190, 16'h01F4, 1'b1, 1'b1);
        wr(srm_pkg::ADDR_ACK, 16'h0001);
        wr(srm_pkg::ADDR_CTRL, 16'h0351);
        meas(16'h0000, 16'h0000, 16'h01F4, 1'b0);
        stat(16'h0000, 16'h01F4, 1'b1, 1'b0);
        repeat (3) @(posedge clk);
        results();
    end
endmodule : testbench
`default_nettype wire
